// >>> opmode_cfg.svh
// Offsets, field positions, reset values and timing counts of the block
`ifndef OPMODE_CFG_SVH
`define OPMODE_CFG_SVH

// Register indices and their byte addresses (index times four)
`define MODE_READBACK_IDX     32'h0000FFF1
`define SYSTEM_CONFIG_IDX     32'h0000FFF2
`define AREA_WIDTH_IDX        32'h0000FFF4
`define BUS_RELEASE_IDX       32'h0000FFF5
`define POWER_STATUS_IDX      32'h0000FFF6
`define MODE_READBACK_ADDR    (`MODE_READBACK_IDX << 2)
`define SYSTEM_CONFIG_ADDR    (`SYSTEM_CONFIG_IDX << 2)
`define AREA_WIDTH_ADDR       (`AREA_WIDTH_IDX << 2)
`define BUS_RELEASE_ADDR      (`BUS_RELEASE_IDX << 2)
`define POWER_STATUS_ADDR     (`POWER_STATUS_IDX << 2)

// Mode readback fixed bits
`define READBACK_FIXED        8'hC0

// System config fields and reset value
`define SYSCFG_RESET          8'h0B
`define SYSCFG_STANDBY_BIT    7
`define SYSCFG_WAIT_HI        6
`define SYSCFG_WAIT_LO        4
`define SYSCFG_ROLE_BIT       3
`define SYSCFG_EDGE_BIT       2
`define SYSCFG_RSVD_BIT       1
`define SYSCFG_RAM_BIT        0
`define SYSCFG_RSVD_MASK      8'h02

// Own registers reset values
`define BUS_RELEASE_RESET     8'hE0
`define AREA_WIDTH_ALL8       8'h00
`define AREA_WIDTH_ALL16      8'hFF

// Settling waits in states (one state is one clock)
`define WAIT_CODE0_STATES     8192
`define WAIT_CODE1_STATES     16384
`define WAIT_CODE2_STATES     32768
`define WAIT_CODE3_STATES     65536
`define WAIT_CODE4_STATES     131072

// On-chip RAM window, low and high address, per address space size
`define RAM_LO_1M             24'h0FEF10
`define RAM_HI_1M             24'h0FFF0F
`define RAM_LO_16M            24'hFFEF10
`define RAM_HI_16M            24'hFFFF0F

// Address output enables per space size
`define ADDR_EN_1M            24'h0FFFFF
`define ADDR_EN_16M_LOW       24'h1FFFFF

`endif

// >>> opmode_pkg.sv
// Types shared by the operating mode and system control block
package opmode_pkg;

   typedef enum logic [2:0] {
      MODE_NONE = 3'h0,
      MODE_1    = 3'h1,
      MODE_2    = 3'h2,
      MODE_3    = 3'h3,
      MODE_4    = 3'h4
   } opmode_t;

   typedef enum logic [1:0] {
      PWR_RUN     = 2'h0,
      PWR_SLEEP   = 2'h1,
      PWR_STANDBY = 2'h2,
      PWR_SETTLE  = 2'h3
   } power_state_t;

endpackage

// >>> sync2.sv
// Two flip-flop synchroniser for pin levels
`timescale 1ns/1ps
module sync2 #(
   parameter int WIDTH = 1
) (
   input  wire logic             hclk,
   input  wire logic             hresetn,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_reg;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         meta_reg <= '0;
         sync_out <= '0;
      end else begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end

endmodule

// >>> settle_timer.sv
// Oscillator settling wait counter after a standby wake-up
`timescale 1ns/1ps
module settle_timer #(
   parameter int WAIT0 = 8192,
   parameter int WAIT1 = 16384,
   parameter int WAIT2 = 32768,
   parameter int WAIT3 = 65536,
   parameter int WAIT4 = 131072
) (
   input  wire logic       hclk,
   input  wire logic       hresetn,
   input  wire logic       start,
   input  wire logic [2:0] wait_code,
   output logic            done
);

   logic [17:0] count_reg;
   logic [17:0] load_value;
   logic        busy_reg;

   // Code 11x has no defined length; it falls to the longest wait
   assign load_value = (wait_code == 3'h0) ? 18'(WAIT0 - 1) :
                       (wait_code == 3'h1) ? 18'(WAIT1 - 1) :
                       (wait_code == 3'h2) ? 18'(WAIT2 - 1) :
                       (wait_code == 3'h3) ? 18'(WAIT3 - 1) :
                                             18'(WAIT4 - 1);
   assign done = busy_reg && (count_reg == 18'h00000);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         count_reg <= 18'h00000;
         busy_reg  <= 1'b0;
      end else if (start) begin
         count_reg <= load_value;
         busy_reg  <= 1'b1;
      end else if (done) begin
         busy_reg  <= 1'b0;
      end else if (busy_reg) begin
         count_reg <= count_reg - 18'h00001;
      end
   end

endmodule

// >>> operating_mode_system_control.sv
// Operating mode decode and system control registers on AHB-Lite
//
// Overview of operation
// - Strap codes 001..100 select modes 1..4: space size and initial bus.
// - RAM enable at 0 sends on-chip RAM addresses to external space.
// - Readback register: bits 7,6 read 1, bits 5..3 read 0, writes ignored.
// - Readback bits 2..0 show strap levels sampled when read.
// - Config bit 7 chooses sleep (0) or software standby (1) on SLEEP.
// - Standby bit stays 1 after interrupt wake; only writing 0 or a reset clears it.
// - Bits 6..4 pick settling wait 8192..131072 states after standby wake.
// - Bit 3 makes the auxiliary flag an interrupt mask (0) or user bit.
// - Bit 2 selects falling (0) or rising (1) edge of the NMI input.
// - Config bit 1 is reserved, reads 1 and ignores writes.
// - Bit 0 enables RAM; reset by the reset pin, kept across standby.
// - Modes 1,2 enable address outputs 19..0; modes 3,4 enable 20..0.
// - Bus is 16-bit if any area is 16-bit; start width follows mode.
// - Modes 3,4: address outputs 23..21 valid once release bits 7..5 are 0.
//
// Local design decision: the AHB-Lite register port.
`timescale 1ns/1ps
`include "opmode_cfg.svh"
module operating_mode_system_control #(
   parameter int WAIT0 = `WAIT_CODE0_STATES,
   parameter int WAIT1 = `WAIT_CODE1_STATES,
   parameter int WAIT2 = `WAIT_CODE2_STATES,
   parameter int WAIT3 = `WAIT_CODE3_STATES,
   parameter int WAIT4 = `WAIT_CODE4_STATES
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic [2:0]  mode_strap_pins,
   input  wire logic        sleep_exec,
   input  wire logic        wake_irq_pin,
   input  wire logic        nmi_pin,
   input  wire logic        auxiliary_flag,
   input  wire logic [23:0] cpu_addr,
   output logic             nmi_request,
   output logic             aux_flag_masks_irq,
   output logic             onchip_ram_select,
   output logic [23:0]      addr_out_en,
   output logic             bus_mode_16,
   output logic             sleep_mode,
   output logic             standby_mode,
   output logic             settling
);

   // Synchronised pins
   logic [2:0] strap_sync;
   logic       wake_sync;
   logic       nmi_sync;
   logic       nmi_prev_reg;

   sync2 #(.WIDTH(3)) u_strap_sync (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .async_in (mode_strap_pins),
      .sync_out (strap_sync)
   );

   sync2 #(.WIDTH(2)) u_event_sync (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .async_in ({wake_irq_pin, nmi_pin}),
      .sync_out ({wake_sync, nmi_sync})
   );

   // Mode decode
   opmode_pkg::opmode_t mode;
   logic                space_16m;
   logic                start_16bit;

   assign mode = opmode_pkg::opmode_t'(strap_sync);
   assign space_16m = (mode == opmode_pkg::MODE_3) ||
                      (mode == opmode_pkg::MODE_4);
   assign start_16bit = (mode == opmode_pkg::MODE_2) ||
                        (mode == opmode_pkg::MODE_4);

   // Registers
   logic [7:0] system_config_reg;
   logic [7:0] system_config_next;
   logic [7:0] area_width_reg;
   logic [7:0] area_width_next;
   logic [7:0] area_start;
   logic [7:0] bus_release_ctrl_reg;
   logic [7:0] bus_release_ctrl_next;
   logic [1:0] init_cnt_reg;
   logic       init_load;

   // Bus capture of the address phase
   logic        wr_pend_reg;
   logic [31:0] wr_addr_reg;
   logic        bus_take;
   logic        rd_take;
   logic        wr_take;

   assign bus_take = hsel && hready && htrans[1];
   assign rd_take  = bus_take && !hwrite;
   assign wr_take  = bus_take && hwrite;

   logic wr_syscfg;
   logic wr_area;
   logic wr_release;

   // Writes to the readback and status registers fall through unheard
   assign wr_syscfg  = wr_pend_reg && (wr_addr_reg == `SYSTEM_CONFIG_ADDR);
   assign wr_area    = wr_pend_reg && (wr_addr_reg == `AREA_WIDTH_ADDR);
   assign wr_release = wr_pend_reg && (wr_addr_reg == `BUS_RELEASE_ADDR);

   // Reserved bit forced high, the rest written as given
   assign system_config_next = wr_syscfg ?
                               (hwdata[7:0] | `SYSCFG_RSVD_MASK) :
                               system_config_reg;

   // Area widths load from the mode once the straps have passed the sync;
   // a write in that same cycle wins, so an early write is not lost
   assign init_load = (init_cnt_reg == 2'h2);
   assign area_start = start_16bit ? `AREA_WIDTH_ALL16 :
                                     `AREA_WIDTH_ALL8;
   assign area_width_next = wr_area   ? hwdata[7:0] :
                            init_load ? area_start :
                                        area_width_reg;
   assign bus_release_ctrl_next = wr_release ? hwdata[7:0] :
                                  bus_release_ctrl_reg;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         system_config_reg <= `SYSCFG_RESET;
      end else begin
         system_config_reg <= system_config_next;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         area_width_reg       <= `AREA_WIDTH_ALL8;
         bus_release_ctrl_reg <= `BUS_RELEASE_RESET;
      end else begin
         area_width_reg       <= area_width_next;
         bus_release_ctrl_reg <= bus_release_ctrl_next;
      end
   end

   // Counts edges after release until the straps are through the sync
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         init_cnt_reg <= 2'h0;
      end else if (init_cnt_reg != 2'h3) begin
         init_cnt_reg <= init_cnt_reg + 2'h1;
      end
   end

   // Field views
   logic       standby_sel;
   logic [2:0] wait_code;
   logic       role_is_user;
   logic       edge_rising;
   logic       ram_enable;

   assign standby_sel  = system_config_reg[`SYSCFG_STANDBY_BIT];
   assign wait_code    = system_config_reg[`SYSCFG_WAIT_HI:`SYSCFG_WAIT_LO];
   assign role_is_user = system_config_reg[`SYSCFG_ROLE_BIT];
   assign edge_rising  = system_config_reg[`SYSCFG_EDGE_BIT];
   assign ram_enable   = system_config_reg[`SYSCFG_RAM_BIT];

   // NMI edge detection on the synchronised level; the history resets low
   // and the falling edge is selected at reset, so a pin that idles high
   // cannot raise a request as it comes through the sync
   logic nmi_edge;

   assign nmi_edge = edge_rising ? (nmi_sync && !nmi_prev_reg) :
                                   (!nmi_sync && nmi_prev_reg);

   // Power state machine
   opmode_pkg::power_state_t pwr_reg;
   opmode_pkg::power_state_t pwr_next;
   logic                     settle_start;
   logic                     settle_done;

   assign settle_start = (pwr_reg == opmode_pkg::PWR_STANDBY) && wake_sync;

   // Standby leaves the config register alone, so the select bit and the
   // RAM enable survive a wake-up
   always_comb begin
      pwr_next = pwr_reg;
      case (pwr_reg)
         opmode_pkg::PWR_RUN: begin
            if (sleep_exec) begin
               pwr_next = standby_sel ? opmode_pkg::PWR_STANDBY :
                                        opmode_pkg::PWR_SLEEP;
            end
         end
         opmode_pkg::PWR_SLEEP: begin
            if (wake_sync || nmi_edge) begin
               pwr_next = opmode_pkg::PWR_RUN;
            end
         end
         opmode_pkg::PWR_STANDBY: begin
            if (wake_sync) begin
               pwr_next = opmode_pkg::PWR_SETTLE;
            end
         end
         opmode_pkg::PWR_SETTLE: begin
            if (settle_done) begin
               pwr_next = opmode_pkg::PWR_RUN;
            end
         end
         default: begin
            pwr_next = opmode_pkg::PWR_RUN;
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pwr_reg <= opmode_pkg::PWR_RUN;
      end else begin
         pwr_reg <= pwr_next;
      end
   end

   settle_timer #(
      .WAIT0 (WAIT0),
      .WAIT1 (WAIT1),
      .WAIT2 (WAIT2),
      .WAIT3 (WAIT3),
      .WAIT4 (WAIT4)
   ) u_settle_timer (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .start     (settle_start),
      .wait_code (wait_code),
      .done      (settle_done)
   );

   // On-chip RAM window and address enables
   logic        in_ram_window;
   logic [23:0] addr_en_next;
   logic        high_addr_valid;

   assign in_ram_window = space_16m ?
      ((cpu_addr >= `RAM_LO_16M) && (cpu_addr <= `RAM_HI_16M)) :
      ((cpu_addr >= `RAM_LO_1M) && (cpu_addr <= `RAM_HI_1M));
   assign high_addr_valid = (bus_release_ctrl_reg[7:5] == 3'h0);
   assign addr_en_next = !space_16m ? `ADDR_EN_1M :
                         (high_addr_valid ? 24'hFFFFFF :
                                            `ADDR_EN_16M_LOW);

   // Edge history and the one-cycle request pulse
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         nmi_prev_reg <= 1'b0;
         nmi_request  <= 1'b0;
      end else begin
         nmi_prev_reg <= nmi_sync;
         nmi_request  <= nmi_edge;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         aux_flag_masks_irq <= 1'b0;
         onchip_ram_select  <= 1'b0;
      end else begin
         aux_flag_masks_irq <= !role_is_user && auxiliary_flag;
         onchip_ram_select  <= ram_enable && in_ram_window;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         addr_out_en <= 24'h000000;
         bus_mode_16 <= 1'b0;
      end else begin
         addr_out_en <= addr_en_next;
         bus_mode_16 <= (area_width_reg != 8'h00);
      end
   end

   // Power levels follow the next state so they line up with the state
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sleep_mode   <= 1'b0;
         standby_mode <= 1'b0;
         settling     <= 1'b0;
      end else begin
         sleep_mode   <= (pwr_next == opmode_pkg::PWR_SLEEP);
         standby_mode <= (pwr_next == opmode_pkg::PWR_STANDBY);
         settling     <= (pwr_next == opmode_pkg::PWR_SETTLE);
      end
   end

   // Read data, taken from next-state values so a read right after a
   // write returns the new contents
   logic [7:0] rd_byte;
   logic [7:0] readback_val;
   logic [7:0] status_val;

   assign readback_val = `READBACK_FIXED | {5'h00, strap_sync};
   assign status_val = {6'h00, pwr_next};
   assign rd_byte =
      (haddr == `MODE_READBACK_ADDR) ? readback_val :
      (haddr == `SYSTEM_CONFIG_ADDR) ? system_config_next :
      (haddr == `AREA_WIDTH_ADDR)    ? area_width_next :
      (haddr == `BUS_RELEASE_ADDR)   ? bus_release_ctrl_next :
      (haddr == `POWER_STATUS_ADDR)  ? status_val :
                                       8'h00;

   // Write address is held for the data phase, where the data arrives
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 32'h00000000;
      end else begin
         wr_pend_reg <= wr_take;
         if (wr_take) begin
            wr_addr_reg <= haddr;
         end
      end
   end

   // Zero wait states: the slave is always ready and always answers OKAY
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata    <= 32'h00000000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         if (rd_take) begin
            hrdata <= {24'h000000, rd_byte};
         end
      end
   end

endmodule

// >>> opmode_chk.sv
// Port checker for the operating mode and system control block
`timescale 1ns/1ps
module opmode_chk (
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        sleep_exec,
   input wire logic [23:0] cpu_addr,
   input wire logic        nmi_request,
   input wire logic        onchip_ram_select,
   input wire logic [23:0] addr_out_en,
   input wire logic        sleep_mode,
   input wire logic        standby_mode,
   input wire logic        settling
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   AST_RB_FIXED: assert property (hsel && hready && htrans[1] && !hwrite &&
      haddr == 32'h0003FFC4 |=> hrdata[7:3] == 5'h18)
      else $error("readback fixed bits wrong");
   AST_CFG_RSVD: assert property (hsel && hready && htrans[1] && !hwrite &&
      haddr == 32'h0003FFC8 |=> hrdata[1])
      else $error("config reserved bit not 1");
   AST_RAM_WINDOW: assert property (onchip_ram_select |->
      $past(cpu_addr[19:0]) >= 20'hFEF10 && $past(cpu_addr[19:0]) <= 20'hFFF0F)
      else $error("RAM select outside window");
   AST_NMI_PULSE: assert property (nmi_request |=> !nmi_request)
      else $error("NMI request longer than one cycle");
   AST_SLEEP_ENTRY: assert property (sleep_exec && !sleep_mode &&
      !standby_mode && !settling |=> sleep_mode ^ standby_mode)
      else $error("SLEEP did not enter a power-down state");
   AST_STBY_WAKE: assert property ($fell(standby_mode) |-> settling)
      else $error("standby left without settling wait");
   AST_SETTLE_BOUND: assert property (settling |-> ##[1:300] !settling)
      else $error("settling wait too long");
   AST_ADDR_WIDTH: assert property (addr_out_en != 24'h0 |->
      addr_out_en[19:0] == 20'hFFFFF)
      else $error("low address outputs not all enabled");
   AST_ADDR_HIGH: assert property (addr_out_en[23:21] != 3'h0 |->
      addr_out_en == 24'hFFFFFF)
      else $error("upper address outputs enabled too early");
   AST_POWER_EXCL: assert property (!(sleep_mode && standby_mode))
      else $error("sleep and standby both active");
endmodule

// >>> opmode_board.sv
// Board model driving the mode straps
`timescale 1ns/1ps
module opmode_board (
   input  wire logic       hclk,
   input  wire logic       hresetn,
   input  wire logic [2:0] code,
   output logic      [2:0] mode_strap_pins
);
   // Straps only move while reset is held, never during operation
   always_ff @(posedge hclk) begin
      if (!hresetn) begin
         mode_strap_pins <= code;
      end
   end
endmodule

// >>> operating_mode_system_control_tb.sv
// Self-checking bench for the operating mode and system control block
`timescale 1ns/1ps
`include "opmode_cfg.svh"
module operating_mode_system_control_tb;
   logic        hclk, hresetn, hsel, hwrite, sleep_exec, wake_irq_pin;
   logic        nmi_pin, auxiliary_flag, hreadyout, nmi_request;
   logic        aux_flag_masks_irq, onchip_ram_select, bus_mode_16;
   logic        sleep_mode, standby_mode, settling, hresp;
   logic [1:0]  htrans;
   logic [2:0]  hsize, strap_code, mode_strap_pins;
   logic [23:0] cpu_addr, addr_out_en;
   logic [31:0] haddr, hwdata, hrdata;
   int          failures, check_count, cycles;

   opmode_board i_opmode_board (.hclk(hclk), .hresetn(hresetn),
      .code(strap_code), .mode_strap_pins(mode_strap_pins));
   // Short settling counts keep the standby walk brief
   operating_mode_system_control #(.WAIT0(8), .WAIT1(16), .WAIT2(32),
      .WAIT3(64), .WAIT4(128)) i_operating_mode_system_control (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .mode_strap_pins(mode_strap_pins),
      .sleep_exec(sleep_exec), .wake_irq_pin(wake_irq_pin),
      .nmi_pin(nmi_pin), .auxiliary_flag(auxiliary_flag),
      .cpu_addr(cpu_addr), .nmi_request(nmi_request),
      .aux_flag_masks_irq(aux_flag_masks_irq),
      .onchip_ram_select(onchip_ram_select), .addr_out_en(addr_out_en),
      .bus_mode_16(bus_mode_16), .sleep_mode(sleep_mode),
      .standby_mode(standby_mode), .settling(settling));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic complete_run;
      if (failures == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // Entered just after a rising edge; waits on ready, never a fixed count
   task automatic xfer(input logic [31:0] a, input logic w,
                       input logic [31:0] d, output logic [31:0] r);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
      check(hresp, 32'h0); // OKAY response
   endtask

   task automatic do_reset(input logic [2:0] c);
      strap_code <= c;
      hresetn <= 1'b0;
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (6) @(posedge hclk);
   endtask

   task automatic test_modes;
      logic [31:0] r;
      for (int m = 1; m <= 4; m++) begin
         do_reset(3'(m));
         check(addr_out_en, (m < 3) ? 32'h0FFFFF : 32'h1FFFFF);
         check(bus_mode_16, m % 2 == 0);
         xfer(`MODE_READBACK_ADDR, 1'b1, 32'hFF, r);
         xfer(`MODE_READBACK_ADDR, 1'b0, 32'h0, r);
         check(r, 32'hC0 | m);
         xfer(`AREA_WIDTH_ADDR, 1'b1, (m % 2 == 0) ? 32'h0 : 32'h10, r);
         repeat (2) @(posedge hclk);
         check(bus_mode_16, m % 2 == 1);
         if (m > 2) begin
            xfer(`BUS_RELEASE_ADDR, 1'b1, 32'h0, r);
            repeat (2) @(posedge hclk);
            check(addr_out_en, 32'hFFFFFF);
         end
      end
   endtask

   task automatic test_config;
      logic [31:0] r;
      xfer(`SYSTEM_CONFIG_ADDR, 1'b0, 32'h0, r);
      check(r, 32'h0B);
      cpu_addr <= 24'hFFEF10;
      auxiliary_flag <= 1'b1;
      repeat (2) @(posedge hclk);
      check({aux_flag_masks_irq, onchip_ram_select}, 32'h1);
      xfer(`SYSTEM_CONFIG_ADDR, 1'b1, 32'h0, r);
      xfer(`SYSTEM_CONFIG_ADDR, 1'b0, 32'h0, r);
      check(r, 32'h02);
      @(posedge hclk);
      check({aux_flag_masks_irq, onchip_ram_select}, 32'h2);
   endtask

   task automatic nmi_edge(input logic lvl, input logic exp);
      logic seen;
      seen = 1'b0;
      nmi_pin <= lvl;
      repeat (8) begin
         @(posedge hclk);
         if (nmi_request === 1'b1) seen = 1'b1;
      end
      check(seen, exp);
   endtask

   task automatic test_nmi;
      logic [31:0] r;
      nmi_edge(1'b0, 1'b1);
      nmi_edge(1'b1, 1'b0);
      xfer(`SYSTEM_CONFIG_ADDR, 1'b1, 32'h04, r);
      nmi_edge(1'b0, 1'b0);
      nmi_edge(1'b1, 1'b1);
   endtask

   task automatic pulse_sleep;
      sleep_exec <= 1'b1;
      @(posedge hclk);
      sleep_exec <= 1'b0;
      repeat (2) @(posedge hclk);
   endtask

   task automatic test_power;
      logic [31:0] r;
      xfer(`SYSTEM_CONFIG_ADDR, 1'b1, 32'h01, r);
      @(posedge hclk);
      pulse_sleep;
      check({sleep_mode, standby_mode}, 32'h2);
      wake_irq_pin <= 1'b1;
      repeat (6) @(posedge hclk);
      wake_irq_pin <= 1'b0;
      check(sleep_mode, 32'h0);
      // Sleep again, left this time by an NMI falling edge
      repeat (3) @(posedge hclk);
      pulse_sleep;
      check({sleep_mode, standby_mode}, 32'h2);
      nmi_pin <= 1'b0;
      repeat (6) @(posedge hclk);
      check(sleep_mode, 32'h0);
      nmi_pin <= 1'b1;
      // RAM off before standby: a standby pass must not restore it
      xfer(`SYSTEM_CONFIG_ADDR, 1'b1, 32'h80, r);
      @(posedge hclk);
      pulse_sleep;
      check({sleep_mode, standby_mode}, 32'h1);
      wake_irq_pin <= 1'b1;
      repeat (5) @(posedge hclk);
      check({standby_mode, settling}, 32'h1);
      wake_irq_pin <= 1'b0;
      repeat (20) @(posedge hclk);
      check({standby_mode, settling}, 32'h0);
      xfer(`SYSTEM_CONFIG_ADDR, 1'b0, 32'h0, r);
      check(r, 32'h82);
   endtask

   // Standby with a given wait code; counts the cycles spent settling
   task automatic settle_len(input logic [2:0] code, input int exp);
      logic [31:0] r;
      int          n;
      n = 0;
      xfer(`SYSTEM_CONFIG_ADDR, 1'b1, 32'h80 | (32'(code) << 4), r);
      pulse_sleep;
      xfer(`POWER_STATUS_ADDR, 1'b0, 32'h0, r);
      check(r, 32'h2);
      wake_irq_pin <= 1'b1;
      repeat (160) begin
         @(posedge hclk);
         if (settling === 1'b1) n++;
      end
      wake_irq_pin <= 1'b0;
      repeat (3) @(posedge hclk);
      check(n, exp);
   endtask

   initial begin
      hclk = 1'b0;
      forever #2.5 hclk = ~hclk;
   end

   always @(posedge hclk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         complete_run;
      end
   end

   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      strap_code = 3'h1;
      sleep_exec = 1'b0;
      wake_irq_pin = 1'b0;
      nmi_pin = 1'b1;
      auxiliary_flag = 1'b0;
      cpu_addr = 24'h0;
      test_modes;
      test_config;
      test_nmi;
      test_power;
      settle_len(3'h1, 16);
      settle_len(3'h5, 128);
      settle_len(3'h6, 128);
      complete_run;
   end
endmodule

bind operating_mode_system_control opmode_chk i_opmode_chk (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
   .sleep_exec(sleep_exec), .cpu_addr(cpu_addr),
   .nmi_request(nmi_request), .onchip_ram_select(onchip_ram_select),
   .addr_out_en(addr_out_en), .sleep_mode(sleep_mode),
   .standby_mode(standby_mode), .settling(settling));
